// file: verilog/io_bus_pkg.sv
// shared constants and types for the processor-side i/o bus sequencer
package io_bus_pkg;

	// ****************************************
	// clock and timing
	// ****************************************
	localparam int CLK_MHZ     = 50;
	localparam int SETUP_NS    = 100;  // select/data settle before strobe
	localparam int STROBE_NS   = 200;  // load strobe width
	localparam int HOLD_NS     = 100;  // select/data hold after strobe
	localparam int READ_NS     = 200;  // board answer settle on read
	localparam int SYSRST_NS   = 1000; // system reset pulse width
	localparam int SYNC_STAGES = 3;

	// least times round up to whole cycles
	function automatic int ns_to_cyc(input int ns);
		int c;
		c = (ns * CLK_MHZ + 999) / 1000;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int SETUP_CYC  = ns_to_cyc(SETUP_NS);
	localparam int STROBE_CYC = ns_to_cyc(STROBE_NS);
	localparam int HOLD_CYC   = ns_to_cyc(HOLD_NS);
	localparam int READ_CYC   = ns_to_cyc(READ_NS) + SYNC_STAGES;
	localparam int SYSRST_CYC = ns_to_cyc(SYSRST_NS);
	localparam int CNT_W      = 8;

	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam logic [7:0] CTRL_OFF   = 8'h00;
	localparam logic [7:0] CMD_OFF    = 8'h04;
	localparam logic [7:0] WDATA_OFF  = 8'h08;
	localparam logic [7:0] RDATA_OFF  = 8'h0c;
	localparam logic [7:0] STATUS_OFF = 8'h10;

	localparam int CTRL_RST_BIT  = 0;
	localparam int CMD_CODE_LSB  = 0;
	localparam int CMD_READ_BIT  = 8;
	localparam int ST_BUSY_BIT   = 0;
	localparam int ST_RST_BIT    = 1;
	localparam int ST_ATTN_LSB   = 2;
	localparam int ST_FLAG_LSB   = 5;

	localparam logic [5:0]  CODE_RESET  = 6'h00;
	localparam logic [15:0] WDATA_RESET = 16'h0000;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_SETUP  = 3'b001,
		ST_STROBE = 3'b010,
		ST_WAIT   = 3'b011,
		ST_HOLD   = 3'b100
	} seq_state_type;

	// synchronised board inputs, active high, bit 0 of data is the msb
	typedef struct packed {
		logic [0:15] data;
		logic [2:0]  attn;  // 2 tape/floppy, 1 disc, 0 mux
		logic [4:0]  flags; // index = flag number
	} board_in_type;

	localparam int BOARD_IN_W = $bits(board_in_type);

endpackage

// file: verilog/pin_sync.sv
// three-stage pin synchroniser that accepts a change once stages two and three agree
module pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] level_out
);
	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;
	logic [WIDTH-1:0] level_q;
	logic [WIDTH-1:0] agree;

	// per bit: take the new value only where the later stages agree
	assign agree = ~(s2_q ^ s3_q);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q    <= '0;
			s2_q    <= '0;
			s3_q    <= '0;
			level_q <= '0;
		end else begin
			s1_q    <= pin_in;
			s2_q    <= s1_q;
			s3_q    <= s2_q;
			level_q <= (agree & s3_q) | (~agree & level_q);
		end
	end

	assign level_out = level_q;
endmodule // pin_sync

// file: verilog/cpu_peripheral_io_bus.sv
// processor-side i/o bus sequencer with apb register access
// Overview of operation
// - 16 data lines, line zero is msb; out on write, in on read.
// - one data path serves programmed i/o and data channel transfers; this sequencer runs programmed i/o cycles only.
// - drive six active-low select lines from instruction bits 10-15, line zero msb.
// - active-low system reset returns every peripheral interface to reset.
// - active-low load strobe pulse during output transfers loads board registers.
// - direction line low for write cycle, high for read cycle.
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
module cpu_peripheral_io_bus (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [0:15] io_data_lines_in,
	output logic      [0:15] io_data_lines_out,
	output logic             io_data_lines_oe,
	output logic      [0:5]  device_select_lines_n,
	output logic             io_write_n,
	output logic             io_load_strobe_n,
	output logic             io_system_reset_n,
	input  wire logic        mux_attention_n,
	input  wire logic        disc_attention_n,
	input  wire logic        tape_attention_n,
	input  wire logic [0:4]  disc_status_flags_n
);
	// ****************************************
	// pin synchronisation
	// ****************************************
	logic [io_bus_pkg::BOARD_IN_W-1:0] raw_in;
	logic [io_bus_pkg::BOARD_IN_W-1:0] sync_out;
	io_bus_pkg::board_in_type          board;

	// inputs turned active high; flag n lands at flags[n]
	assign raw_in = {io_data_lines_in,
		~tape_attention_n, ~disc_attention_n, ~mux_attention_n,
		~disc_status_flags_n[4], ~disc_status_flags_n[3],
		~disc_status_flags_n[2], ~disc_status_flags_n[1],
		~disc_status_flags_n[0]};

	pin_sync #(
		.WIDTH(io_bus_pkg::BOARD_IN_W)
	) u_sync (
		.clk      (pclk),
		.rst_n    (presetn),
		.pin_in   (raw_in),
		.level_out(sync_out)
	);

	assign board = io_bus_pkg::board_in_type'(sync_out);

	// ****************************************
	// apb decode
	// ****************************************
	logic                           sysrst_active;
	io_bus_pkg::seq_state_type      state_q;
	io_bus_pkg::seq_state_type      state_d;
	logic                           busy;
	logic                           setup_phase;
	logic                           access;
	logic                           wr_en;
	logic                           hit_ctrl;
	logic                           hit_cmd;
	logic                           hit_wdata;
	logic                           hit_rdata;
	logic                           hit_status;
	logic                           mapped;
	logic                           cmd_refused;
	logic                           start_cmd;
	logic                           rst_req;

	assign access      = psel & penable;
	assign setup_phase = psel & ~penable;
	assign hit_ctrl    = (paddr == io_bus_pkg::CTRL_OFF);
	assign hit_cmd     = (paddr == io_bus_pkg::CMD_OFF);
	assign hit_wdata   = (paddr == io_bus_pkg::WDATA_OFF);
	assign hit_rdata   = (paddr == io_bus_pkg::RDATA_OFF);
	assign hit_status  = (paddr == io_bus_pkg::STATUS_OFF);
	assign mapped      = hit_ctrl | hit_cmd | hit_wdata | hit_rdata | hit_status;
	assign busy        = (state_q != io_bus_pkg::ST_IDLE);
	// a new cycle or data change is refused while a cycle or reset runs
	assign cmd_refused = (hit_cmd | hit_wdata) & pwrite & (busy | sysrst_active);
	assign wr_en       = access & pwrite & mapped & ~cmd_refused;
	assign start_cmd   = wr_en & hit_cmd;
	assign rst_req     = wr_en & hit_ctrl & pwdata[io_bus_pkg::CTRL_RST_BIT];

	assign pready  = 1'b1;
	assign pslverr = access & (~mapped | cmd_refused);

	// ****************************************
	// software registers
	// ****************************************
	logic [5:0]  code_q;
	logic [5:0]  code_d;
	logic        read_q;
	logic        read_d;
	logic [15:0] wdata_q;
	logic [15:0] rdata_q;
	logic [31:0] prdata_q;
	logic [31:0] rd_mux;
	logic [31:0] status_word;

	// command fields after this edge, so the pins never show a stale command
	assign code_d = start_cmd ? pwdata[io_bus_pkg::CMD_CODE_LSB +: 6] : code_q;
	assign read_d = start_cmd ? pwdata[io_bus_pkg::CMD_READ_BIT] : read_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			code_q  <= io_bus_pkg::CODE_RESET;
			read_q  <= 1'b0;
			wdata_q <= io_bus_pkg::WDATA_RESET;
		end else begin
			code_q <= code_d;
			read_q <= read_d;
			if (wr_en && hit_wdata) begin
				wdata_q <= pwdata[15:0];
			end
		end
	end

	assign status_word = {22'h000000, board.flags, board.attn, sysrst_active, busy};

	assign rd_mux = hit_ctrl   ? {31'h00000000, sysrst_active} :
	                hit_cmd    ? {23'h000000, read_q, 2'b00, code_q} :
	                hit_wdata  ? {16'h0000, wdata_q} :
	                hit_rdata  ? {16'h0000, rdata_q} :
	                hit_status ? status_word : 32'h00000000;

	// read data registered in the setup phase, valid in the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h00000000;
		end else if (setup_phase && !pwrite) begin
			prdata_q <= rd_mux;
		end
	end

	assign prdata = prdata_q;

	// ****************************************
	// system reset pulse
	// ****************************************
	logic [io_bus_pkg::CNT_W-1:0] rst_cnt_q;

	// loaded at power-up so every interface starts from reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_cnt_q <= io_bus_pkg::CNT_W'(io_bus_pkg::SYSRST_CYC);
		end else if (rst_req) begin
			rst_cnt_q <= io_bus_pkg::CNT_W'(io_bus_pkg::SYSRST_CYC);
		end else if (rst_cnt_q != '0) begin
			rst_cnt_q <= rst_cnt_q - 1'b1;
		end
	end

	assign sysrst_active = (rst_cnt_q != '0);

	// ****************************************
	// bus cycle sequencer
	// ****************************************
	logic [io_bus_pkg::CNT_W-1:0] cnt_q;
	logic [io_bus_pkg::CNT_W-1:0] cnt_d;
	logic                         cnt_done;
	logic                         capture;

	assign cnt_done = (cnt_q == '0);
	assign capture  = (state_q == io_bus_pkg::ST_WAIT) && cnt_done;

	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_done ? cnt_q : cnt_q - 1'b1;
		unique case (state_q)
			io_bus_pkg::ST_IDLE: begin
				if (start_cmd) begin
					state_d = io_bus_pkg::ST_SETUP;
					cnt_d   = io_bus_pkg::CNT_W'(io_bus_pkg::SETUP_CYC - 1);
				end
			end
			io_bus_pkg::ST_SETUP: begin
				if (cnt_done && read_q) begin
					state_d = io_bus_pkg::ST_WAIT;
					cnt_d   = io_bus_pkg::CNT_W'(io_bus_pkg::READ_CYC - 1);
				end else if (cnt_done) begin
					state_d = io_bus_pkg::ST_STROBE;
					cnt_d   = io_bus_pkg::CNT_W'(io_bus_pkg::STROBE_CYC - 1);
				end
			end
			io_bus_pkg::ST_STROBE, io_bus_pkg::ST_WAIT: begin
				if (cnt_done) begin
					state_d = io_bus_pkg::ST_HOLD;
					cnt_d   = io_bus_pkg::CNT_W'(io_bus_pkg::HOLD_CYC - 1);
				end
			end
			io_bus_pkg::ST_HOLD: begin
				if (cnt_done) begin
					state_d = io_bus_pkg::ST_IDLE;
				end
			end
			default: begin
				state_d = io_bus_pkg::ST_IDLE;
			end
		endcase
		// a system reset aborts any cycle in progress
		if (sysrst_active) begin
			state_d = io_bus_pkg::ST_IDLE;
			cnt_d   = '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= io_bus_pkg::ST_IDLE;
			cnt_q   <= '0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
		end
	end

	// same data path for programmed i/o write and read words
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_q <= 16'h0000;
		end else if (capture) begin
			rdata_q <= board.data;
		end
	end

	// ****************************************
	// pin drivers
	// ****************************************
	logic [0:5]  sel_n_q;
	logic        write_n_q;
	logic        strobe_n_q;
	logic        oe_q;
	logic [0:15] dout_q;
	logic        in_cycle_d;

	assign in_cycle_d = (state_d != io_bus_pkg::ST_IDLE);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_n_q    <= 6'h3f;
			write_n_q  <= 1'b1;
			strobe_n_q <= 1'b1;
			oe_q       <= 1'b0;
			dout_q     <= 16'h0000;
		end else begin
			// select code bit 10 of the instruction lands on line zero
			sel_n_q    <= in_cycle_d ? ~code_d : 6'h3f;
			write_n_q  <= ~(in_cycle_d & ~read_d);
			strobe_n_q <= ~(state_d == io_bus_pkg::ST_STROBE);
			// data lines released on reads so the board may answer
			oe_q       <= in_cycle_d & ~read_d;
			dout_q     <= wdata_q;
		end
	end

	assign device_select_lines_n = sel_n_q;
	assign io_write_n            = write_n_q;
	assign io_load_strobe_n      = strobe_n_q;
	assign io_data_lines_oe      = oe_q;
	assign io_data_lines_out     = dout_q;
	assign io_system_reset_n     = ~sysrst_active;

endmodule // cpu_peripheral_io_bus

// file: tb/io_bus_properties.sv
// assertion checker for the processor-side i/o bus sequencer
module io_bus_properties (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [7:0]  paddr,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [0:15] io_data_lines_out,
	input wire logic        io_data_lines_oe,
	input wire logic [0:5]  device_select_lines_n,
	input wire logic        io_write_n,
	input wire logic        io_load_strobe_n,
	input wire logic        io_system_reset_n
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire logic unmapped = paddr > 8'h10 || paddr[1:0] != 2'b00;
	wire logic acc = psel && penable;

	strobe_in_write_a: assert property (!io_load_strobe_n |->
		!io_write_n && io_data_lines_oe) else $error("strobe outside write cycle");
	drive_follows_dir_a: assert property (io_data_lines_oe == !io_write_n)
		else $error("data drive disagrees with direction");
	strobe_width_a: assert property ($fell(io_load_strobe_n) |->
		!io_load_strobe_n[*5] ##1 !io_load_strobe_n[*5] ##1 io_load_strobe_n)
		else $error("load strobe width wrong");
	data_steady_a: assert property (!io_load_strobe_n |->
		$stable(io_data_lines_out) && $stable(device_select_lines_n))
		else $error("data or select moved under strobe");
	setup_lead_a: assert property ($fell(io_load_strobe_n) |->
		$past(io_write_n, 5) == 1'b0 && $past(io_write_n, 6) == 1'b1)
		else $error("strobe setup lead wrong");
	hold_tail_a: assert property ($rose(io_load_strobe_n) |->
		!io_write_n[*5] ##1 io_write_n) else $error("hold after strobe wrong");
	ready_now_a: assert property (acc |-> pready) else $error("wait state seen");
	refuse_unmapped_a: assert property (acc && unmapped |-> pslverr)
		else $error("unmapped access not refused");
	reset_idle_a: assert property (!io_system_reset_n && $past(io_system_reset_n) == 1'b0 |->
		io_load_strobe_n && &device_select_lines_n && !io_data_lines_oe)
		else $error("bus not idle under system reset");

	cover property ($fell(io_load_strobe_n));
	cover property (io_write_n && !(&device_select_lines_n));
	cover property (acc && pslverr);
	cover property ($fell(io_system_reset_n));
endmodule // io_bus_properties

bind cpu_peripheral_io_bus io_bus_properties i_props (.pclk, .presetn, .psel, .penable,
	.paddr, .pready, .pslverr, .io_data_lines_out, .io_data_lines_oe,
	.device_select_lines_n, .io_write_n, .io_load_strobe_n, .io_system_reset_n);

// file: tb/io_board_model.sv
// behavioural model of the peripheral interface board
module io_board_model #(
	parameter logic [2:0] DEV = 3'h5
) (
	input  wire logic [0:15] bus_level,
	input  wire logic        pclk,
	input  wire logic [0:5]  device_select_lines_n,
	input  wire logic        io_write_n,
	input  wire logic        io_load_strobe_n,
	input  wire logic        io_system_reset_n,
	input  wire logic [0:15] reply,
	input  wire logic [2:0]  attn,
	input  wire logic [4:0]  flags,
	output logic      [0:15] io_data_lines_in,
	output logic             mux_attention_n,
	output logic             disc_attention_n,
	output logic             tape_attention_n,
	output logic      [0:4]  disc_status_flags_n,
	output logic      [0:15] loaded_q,
	output int               strobes
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// decode, drive and load
	// ****************************************
	logic [0:15] last_q = 16'h0000;
	wire logic [0:5] code = ~device_select_lines_n;
	wire logic hit = code[0:2] == DEV;
	wire logic drive = hit && io_write_n;
	// released lines show the inverse of the last word
	assign io_data_lines_in = drive ? reply : ~last_q;
	always @(posedge pclk) if (drive) last_q <= reply;
	always @(posedge io_load_strobe_n or negedge io_system_reset_n) begin
		if (!io_system_reset_n) loaded_q <= 16'h0000;
		else if (hit) loaded_q <= bus_level;
	end
	int n_strobe_q = 0;
	always @(negedge io_load_strobe_n) n_strobe_q <= n_strobe_q + 1;
	assign strobes = n_strobe_q;
	assign {tape_attention_n, disc_attention_n, mux_attention_n} = ~attn;
	assign disc_status_flags_n = ~{flags[0], flags[1], flags[2], flags[3], flags[4]};
endmodule // io_board_model

// file: tb/cpu_peripheral_io_bus_tb.sv
// self-checking bench for the processor-side i/o bus sequencer
module cpu_peripheral_io_bus_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, err, io_data_lines_oe, io_write_n, io_load_strobe_n;
	logic        io_system_reset_n, mux_attention_n, disc_attention_n, tape_attention_n;
	logic [0:15] io_data_lines_out, io_data_lines_in, bus, loaded, reply = 16'h5a3c;
	logic [0:5]  device_select_lines_n;
	logic [0:4]  disc_status_flags_n;
	logic [2:0]  attn = 3'h0;
	logic [4:0]  flags = 5'h00;
	int          n_errors = 0, n_compared = 0, strobes;

	assign bus = io_data_lines_oe ? io_data_lines_out : io_data_lines_in;
	cpu_peripheral_io_bus i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .io_data_lines_in, .io_data_lines_out, .io_data_lines_oe,
		.device_select_lines_n, .io_write_n, .io_load_strobe_n, .io_system_reset_n,
		.mux_attention_n, .disc_attention_n, .tape_attention_n, .disc_status_flags_n);
	io_board_model i_board (.bus_level(bus), .pclk, .device_select_lines_n, .io_write_n,
		.io_load_strobe_n, .io_system_reset_n, .reply, .attn, .flags, .io_data_lines_in,
		.mux_attention_n, .disc_attention_n, .tape_attention_n, .disc_status_flags_n,
		.loaded_q(loaded), .strobes);

	// ****************************************
	// helpers
	// ****************************************
	initial forever #10 pclk = ~pclk;
	task automatic check(input string what, input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wait_clear(input int b);
		apb(1'b0, 8'h10, 32'h0);
		repeat (60) if (rd[b] !== 1'b0) apb(1'b0, 8'h10, 32'h0);
	endtask
	task automatic finish_test;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset;
		check("sysrst pin", io_system_reset_n, 1'b0);
		check("selects idle", device_select_lines_n, 6'h3f);
		wait_clear(1);
		check("sysrst pin", io_system_reset_n, 1'b1);
	endtask
	task automatic t_write(input logic [5:0] code, input logic [15:0] d);
		apb(1'b1, 8'h08, {16'h0, d});
		apb(1'b1, 8'h04, {26'h0, code});
		for (int i = 0; i < 40 && io_load_strobe_n !== 1'b0; i++) @(posedge pclk);
		check("selects", device_select_lines_n, 6'(~code));
		check("data out", io_data_lines_out, d);
		check("direction", {io_write_n, io_data_lines_oe}, 2'b01);
		wait_clear(0);
		check("board load", loaded, d);
	endtask
	task automatic t_read;
		int s;
		s = strobes;
		apb(1'b1, 8'h04, 32'h0000012a);
		check("read selects", device_select_lines_n, 6'h15);
		check("read direction", {io_write_n, io_data_lines_oe}, 2'b10);
		wait_clear(0);
		apb(1'b0, 8'h0c, 32'h0);
		check("read data", rd, {16'h0, reply});
		check("read strobes", strobes, s);
	endtask
	task automatic t_status;
		attn <= 3'b101;
		flags <= 5'b10110;
		repeat (8) @(posedge pclk);
		apb(1'b0, 8'h10, 32'h0);
		check("attn flags", rd[9:2], 8'hb5);
	endtask
	task automatic t_misc;
		apb(1'b0, 8'h20, 32'h0);
		check("unmapped err", err, 1'b1);
		check("unmapped data", rd, 32'h0);
		apb(1'b1, 8'h00, 32'h1);
		check("sysrst pulse", io_system_reset_n, 1'b0);
		wait_clear(1);
		check("board cleared", loaded, 16'h0);
	endtask

	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_write(6'h28, 16'ha5c3);
		t_write(6'h2f, 16'h3c5a);
		t_read();
		t_status();
		t_misc();
		finish_test();
	end
	initial begin
		repeat (5000) @(posedge pclk);
		n_errors++;
		finish_test();
	end
endmodule // cpu_peripheral_io_bus_tb
